// ==== rtl/rre_defines.vh ====
// Constants for the return and rotate execution block.
`ifndef RRE_DEFINES_VH
`define RRE_DEFINES_VH

// Register byte offsets on the AHB-Lite slave.
`define RRE_OFF_INSTR 6'h00
`define RRE_OFF_STATUS 6'h04
`define RRE_OFF_WREG 6'h08
`define RRE_OFF_PC 6'h0C
`define RRE_OFF_IRQCTL 6'h10
`define RRE_OFF_PWRCTL 6'h14
`define RRE_OFF_FADDR 6'h18
`define RRE_OFF_FDATA 6'h1C
`define RRE_OFF_CYCLES 6'h20

// Field positions.
`define RRE_ST_CARRY 0
`define RRE_ST_DCARRY 1
`define RRE_ST_ZERO 2
`define RRE_ST_BUSY 8
`define RRE_IRQ_EN_BIT 7
`define RRE_RST_FLAG_BIT 2
`define RRE_ROT_DEST_BIT 9

// Reset values.
`define RRE_STATUS_RST 3'h0
`define RRE_WREG_RST 8'h00
`define RRE_PC_RST 15'h0000
`define RRE_IRQCTL_RST 8'h00
`define RRE_PWRCTL_RST 8'h04
`define RRE_FADDR_RST 7'h00
`define RRE_CYCLES_RST 16'h0000

// Opcode encodings.
`define RRE_OP_NOP 16'h0000
`define RRE_OP_RESET 16'h0001
`define RRE_OP_RET_IRQ 16'h0009
`define RRE_OP_RETURN_HI 15'h0009
`define RRE_OP_RET_LIT_HI 8'h0C
`define RRE_OP_ROT_HI 6'h0D

// Instruction classes.
`define RRE_C_NOP 3'h0
`define RRE_C_RESET 3'h1
`define RRE_C_RET_IRQ 3'h2
`define RRE_C_RET_LIT 3'h3
`define RRE_C_RETURN 3'h4
`define RRE_C_ROT 3'h5

// Timing: hclk periods per instruction cycle, and read wait states.
`define RRE_CLKS_PER_CYCLE 4
`define RRE_DIV_LAST 2'h3
`define RRE_RD_WAITS 2'h2

`endif

// ==== rtl/rre_file_mem.v ====
// File register memory, 128 bytes, with registered read data.
`timescale 1ns/1ps
module rre_file_mem (
  input wire hclk,
  input wire [6:0] addr,
  input wire we,
  input wire [7:0] wdata,
  output reg [7:0] rdata
);
  reg [7:0] mem [0:127];

  always @(posedge hclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule // rre_file_mem

// ==== rtl/rre_exec.v ====
// Return and rotate instruction execution unit with an AHB-Lite register slave.
`timescale 1ns/1ps
`include "rre_defines.vh"
module rre_exec (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire [14:0] stack_top,
  output reg stack_pop,
  output reg soft_reset,
  output wire global_irq_enable
);
  localparam S_IDLE = 2'h0;
  localparam S_FETCH = 2'h1;
  localparam S_EXEC = 2'h2;
  localparam S_SECOND = 2'h3;

  reg dph_wr;
  reg [5:0] dph_addr;
  reg [5:0] rd_addr;
  reg [1:0] rd_cnt;
  reg [1:0] div_cnt;
  reg [1:0] state;
  reg [15:0] instr;
  reg [7:0] wreg;
  reg [14:0] pc;
  reg [2:0] stat;
  reg [7:0] irqctl;
  reg [7:0] pwrctl;
  reg [6:0] faddr;
  reg [15:0] cycles;
  reg [31:0] next_rdata;
  wire [7:0] mem_rdata;

  // Maps an opcode onto the class of work it does; unknown codes run as no-operation.
  function [2:0] op_class;
    input [15:0] op;
    begin
      if (op == `RRE_OP_RESET)
        op_class = `RRE_C_RESET;
      else if (op == `RRE_OP_RET_IRQ)
        op_class = `RRE_C_RET_IRQ;
      else if (op[15:1] == `RRE_OP_RETURN_HI)
        op_class = `RRE_C_RETURN;
      else if (op[15:8] == `RRE_OP_RET_LIT_HI)
        op_class = `RRE_C_RET_LIT;
      else if (op[15:10] == `RRE_OP_ROT_HI && op[7] == 1'b0)
        op_class = `RRE_C_ROT;
      else
        op_class = `RRE_C_NOP;
    end
  endfunction

  wire busy = (state != S_IDLE);
  wire accept = hsel & htrans[1] & hready;
  wire bus_wr = dph_wr;
  wire cyc_en = (div_cnt == `RRE_DIV_LAST);
  wire [2:0] cls = op_class(instr);
  wire exec_now = (state == S_EXEC) & cyc_en;
  wire [7:0] rot_res = {mem_rdata[6:0], stat[`RRE_ST_CARRY]};
  wire exec_we = exec_now & (cls == `RRE_C_ROT) & instr[`RRE_ROT_DEST_BIT];
  wire bus_fwe = bus_wr & (dph_addr == `RRE_OFF_FDATA) & ~busy;
  wire [6:0] mem_addr = busy ? instr[6:0] : faddr;
  wire [7:0] mem_wdata = exec_we ? rot_res : hwdata[7:0];
  wire two_cycle = (op_class(instr) == `RRE_C_RET_IRQ) | (cls == `RRE_C_RET_LIT) | (cls == `RRE_C_RETURN);

  assign hreadyout = (rd_cnt == 2'h0);
  assign hresp = 1'b0;
  assign global_irq_enable = irqctl[`RRE_IRQ_EN_BIT];

  rre_file_mem u_mem (
    .hclk(hclk),
    .addr(mem_addr),
    .we(exec_we | bus_fwe),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  // Bus phase tracking: writes finish with no wait, reads take two wait states.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr <= 1'b0;
      dph_addr <= 6'h00;
      rd_addr <= 6'h00;
      rd_cnt <= 2'h0;
      hrdata <= 32'h00000000;
    end else begin
      dph_wr <= accept & hwrite;
      if (accept) begin
        dph_addr <= haddr[5:0];
      end
      if (accept & ~hwrite) begin
        rd_addr <= haddr[5:0];
        rd_cnt <= `RRE_RD_WAITS;
      end else if (rd_cnt != 2'h0) begin
        rd_cnt <= rd_cnt - 2'h1;
      end
      if (rd_cnt == 2'h1) begin
        hrdata <= next_rdata;
      end
    end
  end

  always @* begin
    next_rdata = 32'h00000000;
    case (rd_addr)
      `RRE_OFF_INSTR: next_rdata = {16'h0000, instr};
      `RRE_OFF_STATUS: next_rdata = {23'h000000, busy, 5'h00, stat};
      `RRE_OFF_WREG: next_rdata = {24'h000000, wreg};
      `RRE_OFF_PC: next_rdata = {17'h00000, pc};
      `RRE_OFF_IRQCTL: next_rdata = {24'h000000, irqctl};
      `RRE_OFF_PWRCTL: next_rdata = {24'h000000, pwrctl};
      `RRE_OFF_FADDR: next_rdata = {25'h0000000, faddr};
      `RRE_OFF_FDATA: next_rdata = busy ? 32'h00000000 : {24'h000000, mem_rdata};
      `RRE_OFF_CYCLES: next_rdata = {16'h0000, cycles};
      default: next_rdata = 32'h00000000;
    endcase
  end

  // Instruction cycle divider; it runs free so issue timing never depends on the bus.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt <= 2'h0;
    end else begin
      div_cnt <= div_cnt + 2'h1;
    end
  end

  // Register file and execution sequencer; execution wins over a bus write in the same cycle.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= S_IDLE;
      instr <= `RRE_OP_NOP;
      wreg <= `RRE_WREG_RST;
      pc <= `RRE_PC_RST;
      stat <= `RRE_STATUS_RST;
      irqctl <= `RRE_IRQCTL_RST;
      pwrctl <= `RRE_PWRCTL_RST;
      faddr <= `RRE_FADDR_RST;
      cycles <= `RRE_CYCLES_RST;
      stack_pop <= 1'b0;
      soft_reset <= 1'b0;
    end else if (soft_reset) begin
      // The cycle after the reset opcode restores every sequencer register's reset value except the pwrctl reset flag bit, which it clears.
      state <= S_IDLE;
      instr <= `RRE_OP_NOP;
      wreg <= `RRE_WREG_RST;
      pc <= `RRE_PC_RST;
      stat <= `RRE_STATUS_RST;
      irqctl <= `RRE_IRQCTL_RST;
      pwrctl <= `RRE_PWRCTL_RST & ~(8'h01 << `RRE_RST_FLAG_BIT);
      faddr <= `RRE_FADDR_RST;
      cycles <= `RRE_CYCLES_RST;
      stack_pop <= 1'b0;
      soft_reset <= 1'b0;
    end else begin
      stack_pop <= 1'b0;
      if (bus_wr) begin
        case (dph_addr)
          `RRE_OFF_INSTR: begin
            if (!busy) begin
              instr <= hwdata[15:0];
            end
          end
          `RRE_OFF_STATUS: stat <= hwdata[2:0];
          `RRE_OFF_WREG: wreg <= hwdata[7:0];
          `RRE_OFF_PC: pc <= hwdata[14:0];
          `RRE_OFF_IRQCTL: irqctl <= hwdata[7:0];
          `RRE_OFF_PWRCTL: pwrctl <= hwdata[7:0];
          `RRE_OFF_FADDR: faddr <= hwdata[6:0];
          default: faddr <= faddr;
        endcase
      end
      case (state)
        S_IDLE: begin
          // An opcode write issues only from idle; a write while busy is dropped.
          if (bus_wr && (dph_addr == `RRE_OFF_INSTR)) begin
            state <= S_FETCH;
          end
        end
        S_FETCH: state <= S_EXEC;
        S_EXEC: begin
          if (cyc_en) begin
            cycles <= cycles + 16'h0001;
            state <= two_cycle ? S_SECOND : S_IDLE;
            case (cls)
              `RRE_C_RESET: soft_reset <= 1'b1;
              `RRE_C_RET_IRQ: begin
                pc <= stack_top;
                stack_pop <= 1'b1;
                irqctl[`RRE_IRQ_EN_BIT] <= 1'b1;
              end
              `RRE_C_RET_LIT: begin
                wreg <= instr[7:0];
                pc <= stack_top;
                stack_pop <= 1'b1;
              end
              `RRE_C_RETURN: begin
                pc <= stack_top;
                stack_pop <= 1'b1;
              end
              `RRE_C_ROT: begin
                stat[`RRE_ST_CARRY] <= mem_rdata[7];
                if (!instr[`RRE_ROT_DEST_BIT]) begin
                  wreg <= rot_res;
                end
                pc <= pc + 15'h0001;
              end
              default: pc <= pc + 15'h0001;
            endcase
          end
        end
        S_SECOND: begin
          if (cyc_en) begin
            // Second cycle of a return: flush slot; only the cycle counter advances.
            cycles <= cycles + 16'h0001;
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule // rre_exec

// ==== tb/rre_exec_monitor.sv ====
// Concurrent checks on the ports of the return and rotate execution block.
`timescale 1ns/1ps
module rre_exec_monitor (
  input wire hclk,
  input wire hresetn,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  input wire stack_pop,
  input wire soft_reset,
  input wire global_irq_enable
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_read_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  sequence s_quiet_pop;
    !stack_pop [*6];
  endsequence
  a_bus_okay: assert property (hresp == 1'b0) else $error("hresp is not OKAY");
  a_wait_two: assert property ($fell(hreadyout) |=> s_read_wait) else $error("read wait is not two cycles");
  a_wait_bound: assert property (!hreadyout |-> ##[1:2] hreadyout) else $error("read wait too long");
  a_pop_single: assert property (stack_pop |=> s_quiet_pop) else $error("stack pop repeated");
  a_pop_alone: assert property (stack_pop |-> !soft_reset) else $error("pop during soft reset");
  a_reset_single: assert property (soft_reset |=> !soft_reset [*4]) else $error("soft reset repeated");
  a_reset_irq_off: assert property (soft_reset |=> !global_irq_enable) else $error("irq enable kept");
  a_data_hold: assert property ($changed(hrdata) |-> $rose(hreadyout)) else $error("read data moved outside a read");
  a_reset_nopop: assert property (soft_reset |=> !stack_pop [*2]) else $error("pop after reset");
endmodule // rre_exec_monitor

bind rre_exec rre_exec_monitor mon_u (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .stack_pop(stack_pop), .soft_reset(soft_reset), .global_irq_enable(global_irq_enable), .hrdata(hrdata));

// ==== tb/return_rotate_exec_test.sv ====
// Bus-driven testbench for the return and rotate execution block.
`timescale 1ns/1ps
module return_rotate_exec_test;
  reg hclk = 1'b0;
  reg hresetn = 1'b0;
  reg hwrite = 1'b0;
  reg [31:0] haddr = 32'h00000000;
  reg [31:0] hwdata = 32'h00000000;
  reg [31:0] r;
  reg [1:0] htrans = 2'h0;
  reg [14:0] stack_top = 15'h0000;
  wire hreadyout;
  wire hresp;
  wire stack_pop;
  wire soft_reset;
  wire irq_en;
  wire [31:0] hrdata;
  integer failures = 0;
  integer total_checks = 0;
  integer pops = 0;
  integer resets = 0;
  integer i;
  reg [15:0] ops [0:3];

  rre_exec dut_u (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(1'b1),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(3'h2),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .stack_top(stack_top),
    .stack_pop(stack_pop),
    .soft_reset(soft_reset),
    .global_irq_enable(irq_en)
  );

  initial begin
    forever begin
      #12.5 hclk = ~hclk;
    end
  end

  always @(posedge hclk) begin
    pops <= pops + stack_pop;
    resets <= resets + soft_reset;
  end

  task conclude;
    begin
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
        $display("ALL TESTS PASSED");
      end else begin
        $display("TESTS FAILED");
      end
      $finish;
    end
  endtask

  task chk(input [31:0] seen, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  // One single AHB-Lite transfer; read data are taken at the edge that ends the data phase.
  task xfer(input [31:0] a, input w, input [31:0] d);
    begin
      @(posedge hclk);
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
    end
  endtask

  task rd(input [31:0] a, input [31:0] exp);
    begin
      xfer(a, 1'b0, 32'h00000000);
      chk(r, exp);
    end
  endtask

  task run(input [15:0] op);
    integer n;
    begin
      xfer(32'h00000000, 1'b1, {16'h0000, op});
      n = 0;
      do begin
        xfer(32'h00000004, 1'b0, 32'h00000000);
        n = n + 1;
      end while (r[8] !== 1'b0 && n < 20);
    end
  endtask

  initial begin
    ops[0] = 16'h0009;
    ops[1] = 16'h0012;
    ops[2] = 16'h0013;
    ops[3] = 16'h0CA5;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rd(32'h00000014, 32'h00000004);
    rd(32'h0000003C, 32'h00000000);
    xfer(32'h0000000C, 1'b1, 32'h00000005);
    xfer(32'h00000004, 1'b1, 32'h00000001);
    run(16'h0000);
    rd(32'h0000000C, 32'h00000006);
    rd(32'h00000004, 32'h00000001);
    rd(32'h00000020, 32'h00000001);
    $display("nop test done");
    for (i = 0; i < 2; i = i + 1) begin
      xfer(32'h00000018, 1'b1, i ? 32'h00000000 : 32'h0000007F);
      xfer(32'h0000001C, 1'b1, i ? 32'h00000081 : 32'h000000E6);
      xfer(32'h00000004, 1'b1, i ? 32'h00000007 : 32'h00000006);
      xfer(32'h00000008, 1'b1, 32'h00000055);
      run(i ? 16'h3600 : 16'h347F);
      rd(32'h00000004, 32'h00000007);
      rd(32'h00000008, i ? 32'h00000055 : 32'h000000CC);
      rd(32'h0000001C, i ? 32'h00000003 : 32'h000000E6);
    end
    rd(32'h00000020, 32'h00000003);
    $display("rotate test done");
    for (i = 0; i < 4; i = i + 1) begin
      stack_top <= 15'h1234 + i[14:0];
      xfer(32'h00000010, 1'b1, 32'h00000000);
      xfer(32'h00000008, 1'b1, 32'h00000011);
      run(ops[i]);
      rd(32'h0000000C, 32'h00001234 + i);
      rd(32'h00000004, 32'h00000007);
      chk(pops, i + 1);
      rd(32'h00000008, (i == 3) ? 32'h000000A5 : 32'h00000011);
      chk({31'h00000000, irq_en}, (i == 0) ? 32'h00000001 : 32'h00000000);
    end
    rd(32'h00000020, 32'h0000000B);
    $display("return test done");
    xfer(32'h00000010, 1'b1, 32'h00000080);
    xfer(32'h00000008, 1'b1, 32'h0000003C);
    run(16'h0001);
    chk(resets, 1);
    rd(32'h00000014, 32'h00000000);
    rd(32'h00000010, 32'h00000000);
    rd(32'h00000008, 32'h00000000);
    rd(32'h0000000C, 32'h00000000);
    $display("reset test done");
    conclude;
  end

  // The tests need a few hundred clocks; this limit of 20000 clocks is far beyond that.
  initial begin
    #(25 * 20000);
    failures = failures + 1;
    conclude;
  end
endmodule // return_rotate_exec_test
